/* File: verilog/phy_regs_pkg.sv */
// phy management register bank: indices, field positions, reset values, carriers
// assumes one aclk domain and a 32-bit axi4-lite slave with 16-bit registers
package phy_regs_pkg;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_P2_CTL = 8'h00;
  localparam logic [7:0] IDX_P1_ADV = 8'h08;
  localparam logic [7:0] IDX_P1_LP = 8'h0a;
  localparam logic [7:0] IDX_P1_ALIAS_CTL = 8'h10;
  localparam logic [7:0] IDX_P1_ALIAS_STS = 8'h12;
  localparam logic [7:0] IDX_P2_ALIAS_CTL = 8'h14;
  localparam logic [7:0] IDX_P2_ALIAS_STS = 8'h16;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int P2_LOOPBACK = 14;
  localparam int P2_FORCE_100 = 13;
  localparam int P2_AN_ENABLE = 12;
  localparam int P2_POWER_DOWN = 11;
  localparam int P2_RESTART = 9;
  localparam int P2_FORCE_FULL = 8;
  localparam int P2_XOVER_SEL = 5;
  localparam int P2_FORCE_MDIX = 4;
  localparam int P2_DIS_MDIX = 3;
  localparam int P2_DIS_FAR_FAULT = 2;
  localparam int P2_DIS_TX = 1;
  localparam int P2_DIS_LED = 0;
  localparam int A2_FORCE_FULL = 5;
  localparam int A2_FORCE_100 = 6;
  localparam int A2_AN_ENABLE = 7;
  localparam int A2_LOOPBACK = 8;
  localparam int A2_FORCE_MDIX = 9;
  localparam int A2_DIS_MDIX = 10;
  localparam int A2_POWER_DOWN = 11;
  localparam int A2_DIS_FAR_FAULT = 12;
  localparam int A2_RESTART = 13;
  localparam int A2_DIS_TX = 14;
  localparam int A2_DIS_LED = 15;
  localparam int A2S_XOVER_SEL = 15;
  localparam int ADV_PAUSE = 10;
  localparam int ADV_RSVD = 9;
  localparam int ADV_ABIL_LSB = 5;
  localparam logic [4:0] SELECTOR_8023 = 5'h01;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic loopback;
    logic force_100;
    logic an_enable;
    logic power_down;
    logic restart_an;
    logic force_full;
    logic crossover_variant_select;
    logic force_mdix;
    logic disable_auto_mdix;
    logic disable_far_fault;
    logic disable_tx;
    logic disable_led;
  } port2_ctl_s;

  // order matches bits 4..0 of the alias views
  typedef struct packed {
    logic pause;
    logic full_100;
    logic half_100;
    logic full_10;
    logic half_10;
  } ability_s;

  typedef struct packed {
    logic speed_100;
    logic full_duplex;
  } link_mode_s;

  // ----------------------------------------------------------------
  // reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [11:0] P2_CTL_RST = 12'h220;
  localparam logic [4:0] ADV_RST = 5'h1f;
  localparam logic [4:0] LP_RST = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: verilog/partner_capture.sv */
// holds the port 1 link partner abilities reported by the phy
// assumes update and ability_in are synchronous to aclk
`timescale 1ns/100ps
module partner_capture
  import phy_regs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic update,
  input wire ability_s ability_in,
  output ability_s ability
);

  typedef struct packed {
    ability_s lp;
  } state_s;

  state_s s_q;
  state_s s_d;

  always_comb
  begin
    s_d = s_q;
    if (update)
    begin
      s_d.lp = ability_in;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q.lp <= ability_s'(LP_RST);
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign ability = s_q.lp;

endmodule

/* File: verilog/link_mode_resolve.sv */
// picks the operating speed and duplex of port 2 from control and negotiation
// assumes negotiation status inputs are synchronous to aclk
`timescale 1ns/100ps
module link_mode_resolve
  import phy_regs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire port2_ctl_s ctl,
  input wire logic an_failed,
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  output link_mode_s mode
);

  typedef struct packed {
    link_mode_s m;
  } state_s;

  state_s s_q;
  state_s s_d;

  always_comb
  begin
    s_d = s_q;
    // forced speed only counts with negotiation off
    s_d.m.speed_100 = ctl.an_enable ? an_speed_100 : ctl.force_100;
    // forced duplex also covers a failed negotiation
    if (!ctl.an_enable || an_failed)
    begin
      s_d.m.full_duplex = ctl.force_full;
    end
    else
    begin
      s_d.m.full_duplex = an_full_duplex;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q.m <= 2'h0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign mode = s_q.m;

endmodule

/* File: verilog/phy_mii_control_advert_regs.sv */
// phy management registers: port 2 basic control, port 1 advertisement and
// partner ability, plus alias views that share the same storage
// assumes an axi4-lite master on aclk and phy status synchronous to aclk
//
// Operation
// - advertisement bit 10 pause, read/write, resets 1, shared with alias bit 4
// - advertisement bits 8..5 read/write, reset 1, shared with alias bits 3..0
// - partner bit 10 read-only pause ability, resets 0, mirrors status alias bit 4
// - partner bits 8..5 read-only abilities, reset 0, mirror status alias bits 3..0
// - port 2 bit 14 loopback at the medium layers, resets 0
// - port 2 bit 13 forced speed, 1 is 100, resets 0, alias bit 6
// - port 2 bit 12 negotiation enable, resets 1, alias bit 7
// - port 2 bit 11 power-down, resets 0, alias bit 11
// - port 2 bit 9 writing 1 restarts negotiation, resets 0, alias bit 13
// - port 2 bit 8 forced duplex, 1 is full, resets 0, alias bit 5
// - port 2 bit 5 crossover variant select, resets 1, status alias bit 15
// - port 2 bit 4 forces crossed pin assignment, resets 0, alias bit 9
// - port 2 bit 3 disables automatic crossover, resets 0, alias bit 10
// - port 2 bit 2 disables far-end-fault detection, resets 0, alias bit 12
// - port 2 bit 1 disables the transmitter, resets 0, alias bit 14
// - port 2 bit 0 turns off the leds, resets 0, alias bit 15
// - port 2 bits 15, 10, 7 and 6 read zero and ignore writes
// - forced speed needs negotiation off; forced duplex also when negotiation failed
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
module phy_mii_control_advert_regs
  import phy_regs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic p1_partner_update,
  input wire ability_s p1_partner_in,
  input wire logic p2_an_failed,
  input wire logic p2_an_speed_100,
  input wire logic p2_an_full_duplex,
  output port2_ctl_s port2_ctl,
  output ability_s port1_adv,
  output logic p2_restart_pulse,
  output link_mode_s p2_mode
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    port2_ctl_s ctl;
    ability_s adv;
    logic adv_rsvd;
  } fields_s;

  typedef struct packed {
    fields_s f;
    logic [7:0] aw_idx;
    logic aw_full;
    logic [15:0] wdat;
    logic [1:0] wstr;
    logic w_full;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic restart;
  } state_s;

  typedef struct packed {
    logic hit;
    logic [15:0] value;
  } view_s;

  state_s s_q;
  state_s s_d;
  ability_s lp;

  // ----------------------------------------------------------------
  // register views
  // ----------------------------------------------------------------
  // every view is built from the same fields, so aliases cannot diverge
  function automatic view_s read_view(input logic [7:0] idx, input fields_s f,
                                      input ability_s partner);
    view_s v;
    v = '0;
    v.hit = 1'b1;
    case (idx)
      IDX_P2_CTL:
      begin
        v.value[P2_LOOPBACK] = f.ctl.loopback;
        v.value[P2_FORCE_100] = f.ctl.force_100;
        v.value[P2_AN_ENABLE] = f.ctl.an_enable;
        v.value[P2_POWER_DOWN] = f.ctl.power_down;
        v.value[P2_RESTART] = f.ctl.restart_an;
        v.value[P2_FORCE_FULL] = f.ctl.force_full;
        v.value[P2_XOVER_SEL] = f.ctl.crossover_variant_select;
        v.value[P2_FORCE_MDIX] = f.ctl.force_mdix;
        v.value[P2_DIS_MDIX] = f.ctl.disable_auto_mdix;
        v.value[P2_DIS_FAR_FAULT] = f.ctl.disable_far_fault;
        v.value[P2_DIS_TX] = f.ctl.disable_tx;
        v.value[P2_DIS_LED] = f.ctl.disable_led;
      end
      IDX_P2_ALIAS_CTL:
      begin
        v.value[A2_LOOPBACK] = f.ctl.loopback;
        v.value[A2_FORCE_100] = f.ctl.force_100;
        v.value[A2_AN_ENABLE] = f.ctl.an_enable;
        v.value[A2_POWER_DOWN] = f.ctl.power_down;
        v.value[A2_RESTART] = f.ctl.restart_an;
        v.value[A2_FORCE_FULL] = f.ctl.force_full;
        v.value[A2_FORCE_MDIX] = f.ctl.force_mdix;
        v.value[A2_DIS_MDIX] = f.ctl.disable_auto_mdix;
        v.value[A2_DIS_FAR_FAULT] = f.ctl.disable_far_fault;
        v.value[A2_DIS_TX] = f.ctl.disable_tx;
        v.value[A2_DIS_LED] = f.ctl.disable_led;
      end
      IDX_P2_ALIAS_STS:
      begin
        v.value[A2S_XOVER_SEL] = f.ctl.crossover_variant_select;
      end
      IDX_P1_ADV:
      begin
        v.value[ADV_PAUSE] = f.adv.pause;
        v.value[ADV_RSVD] = f.adv_rsvd;
        v.value[ADV_ABIL_LSB+:4] = f.adv[3:0];
        v.value[4:0] = SELECTOR_8023;
      end
      IDX_P1_ALIAS_CTL:
      begin
        v.value[4:0] = f.adv;
      end
      IDX_P1_LP:
      begin
        v.value[ADV_PAUSE] = partner.pause;
        v.value[ADV_ABIL_LSB+:4] = partner[3:0];
        v.value[4:0] = SELECTOR_8023;
      end
      IDX_P1_ALIAS_STS:
      begin
        v.value[4:0] = partner;
      end
      default:
      begin
        v.hit = 1'b0;
      end
    endcase
    return v;
  endfunction

  // bits not decoded here are read-only or unused and drop silently
  function automatic fields_s write_view(input logic [7:0] idx, input logic [15:0] v,
                                         input fields_s f);
    fields_s n;
    n = f;
    case (idx)
      IDX_P2_CTL:
      begin
        // bits 15, 10, 7 and 6 have no storage
        n.ctl.loopback = v[P2_LOOPBACK];
        n.ctl.force_100 = v[P2_FORCE_100];
        n.ctl.an_enable = v[P2_AN_ENABLE];
        n.ctl.power_down = v[P2_POWER_DOWN];
        n.ctl.restart_an = v[P2_RESTART];
        n.ctl.force_full = v[P2_FORCE_FULL];
        n.ctl.crossover_variant_select = v[P2_XOVER_SEL];
        n.ctl.force_mdix = v[P2_FORCE_MDIX];
        n.ctl.disable_auto_mdix = v[P2_DIS_MDIX];
        n.ctl.disable_far_fault = v[P2_DIS_FAR_FAULT];
        n.ctl.disable_tx = v[P2_DIS_TX];
        n.ctl.disable_led = v[P2_DIS_LED];
      end
      IDX_P2_ALIAS_CTL:
      begin
        n.ctl.loopback = v[A2_LOOPBACK];
        n.ctl.force_100 = v[A2_FORCE_100];
        n.ctl.an_enable = v[A2_AN_ENABLE];
        n.ctl.power_down = v[A2_POWER_DOWN];
        n.ctl.restart_an = v[A2_RESTART];
        n.ctl.force_full = v[A2_FORCE_FULL];
        n.ctl.force_mdix = v[A2_FORCE_MDIX];
        n.ctl.disable_auto_mdix = v[A2_DIS_MDIX];
        n.ctl.disable_far_fault = v[A2_DIS_FAR_FAULT];
        n.ctl.disable_tx = v[A2_DIS_TX];
        n.ctl.disable_led = v[A2_DIS_LED];
      end
      IDX_P2_ALIAS_STS:
      begin
        n.ctl.crossover_variant_select = v[A2S_XOVER_SEL];
      end
      IDX_P1_ADV:
      begin
        n.adv.pause = v[ADV_PAUSE];
        n.adv_rsvd = v[ADV_RSVD];
        n.adv[3:0] = v[ADV_ABIL_LSB+:4];
      end
      IDX_P1_ALIAS_CTL:
      begin
        n.adv = v[4:0];
      end
      default:
      begin
        n = f;
      end
    endcase
    return n;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    view_s wv;
    view_s rv;
    logic [15:0] mask;
    logic [15:0] merged;
    wv = '0;
    rv = '0;
    mask = '0;
    merged = '0;
    s_d = s_q;
    s_d.restart = 1'b0;
    if (awvalid && awready)
    begin
      s_d.aw_idx = awaddr[9:2];
      s_d.aw_full = 1'b1;
    end
    if (wvalid && wready)
    begin
      s_d.wdat = wdata[15:0];
      s_d.wstr = wstrb[1:0];
      s_d.w_full = 1'b1;
    end
    if (s_q.bvalid && bready)
    begin
      s_d.bvalid = 1'b0;
    end
    // commit once both halves are in; response waits for the old one
    if (s_q.aw_full && s_q.w_full && !s_q.bvalid)
    begin
      wv = read_view(s_q.aw_idx, s_q.f, lp);
      mask = {{8{s_q.wstr[1]}}, {8{s_q.wstr[0]}}};
      merged = (wv.value & ~mask) | (s_q.wdat & mask);
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = wv.hit ? RESP_OKAY : RESP_SLVERR;
      if (wv.hit)
      begin
        s_d.f = write_view(s_q.aw_idx, merged, s_q.f);
      end
      // the pulse follows a written 1, not the stored bit
      if (s_q.wstr[1])
      begin
        if (s_q.aw_idx == IDX_P2_CTL && s_q.wdat[P2_RESTART])
        begin
          s_d.restart = 1'b1;
        end
        if (s_q.aw_idx == IDX_P2_ALIAS_CTL && s_q.wdat[A2_RESTART])
        begin
          s_d.restart = 1'b1;
        end
      end
    end
    if (s_q.rvalid && rready)
    begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && arready)
    begin
      rv = read_view(araddr[9:2], s_q.f, lp);
      s_d.rdata = {16'h0000, rv.value};
      s_d.rresp = rv.hit ? RESP_OKAY : RESP_SLVERR;
      s_d.rvalid = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.f.ctl <= port2_ctl_s'(P2_CTL_RST);
      s_q.f.adv <= ability_s'(ADV_RST);
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // partner abilities and mode resolution
  // ----------------------------------------------------------------
  partner_capture u_partner (
    .aclk(aclk),
    .aresetn(aresetn),
    .update(p1_partner_update),
    .ability_in(p1_partner_in),
    .ability(lp)
  );

  link_mode_resolve u_mode (
    .aclk(aclk),
    .aresetn(aresetn),
    .ctl(s_q.f.ctl),
    .an_failed(p2_an_failed),
    .an_speed_100(p2_an_speed_100),
    .an_full_duplex(p2_an_full_duplex),
    .mode(p2_mode)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // one write and one read outstanding; a second waits on ready
  assign awready = !s_q.aw_full && !s_q.bvalid;
  assign wready = !s_q.w_full && !s_q.bvalid;
  assign arready = !s_q.rvalid;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign port2_ctl = s_q.f.ctl;
  assign port1_adv = s_q.f.adv;
  assign p2_restart_pulse = s_q.restart;

endmodule

/* File: bench/phy_regs_checker.sv */
// assertions on the ports of the phy management register bank
// assumes one aclk domain with synchronous active-low reset
`timescale 1ns/100ps
module phy_regs_checker
  import phy_regs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic p2_an_failed,
  input wire logic p2_an_speed_100,
  input wire logic p2_an_full_duplex,
  input wire port2_ctl_s port2_ctl,
  input wire ability_s port1_adv,
  input wire logic p2_restart_pulse,
  input wire link_mode_s p2_mode
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // write and read handshakes
  // ----------------------------------------------------------------
  sequence wr_both;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence resp_rise;
    !bvalid ##1 bvalid;
  endsequence

  a_write_resp: assert property (wr_both |=> resp_rise)
    else $error("write response not two cycles after address and data");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before ready");
  a_read_next: assert property (arvalid && arready |=> rvalid)
    else $error("read data not one cycle after address");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before ready");
  a_upper_zero: assert property (rvalid |-> rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");

  // ----------------------------------------------------------------
  // fields, reset values, restart pulse, resolved mode
  // ----------------------------------------------------------------
  a_field_by_write: assert property (
    !$stable(port2_ctl) || !$stable(port1_adv) |-> $rose(bvalid))
    else $error("field changed without a completed write");
  a_reset_fields: assert property (
    $rose(aresetn) |-> port2_ctl == P2_CTL_RST && port1_adv == ADV_RST)
    else $error("field reset values wrong");
  a_restart_pulse: assert property (
    p2_restart_pulse |-> $rose(bvalid) && port2_ctl.restart_an ##1 !p2_restart_pulse)
    else $error("restart pulse without restart write");
  a_speed_mode: assert property (
    $past(aresetn) |-> p2_mode.speed_100 == ($past(port2_ctl.an_enable) ?
    $past(p2_an_speed_100) : $past(port2_ctl.force_100)))
    else $error("resolved speed wrong");
  a_duplex_mode: assert property (
    $past(aresetn) |-> p2_mode.full_duplex ==
    ((!$past(port2_ctl.an_enable) || $past(p2_an_failed)) ?
    $past(port2_ctl.force_full) : $past(p2_an_full_duplex)))
    else $error("resolved duplex wrong");
endmodule

bind phy_mii_control_advert_regs phy_regs_checker chk_u (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .p2_an_failed(p2_an_failed), .p2_an_speed_100(p2_an_speed_100),
  .p2_an_full_duplex(p2_an_full_duplex), .port2_ctl(port2_ctl), .port1_adv(port1_adv),
  .p2_restart_pulse(p2_restart_pulse), .p2_mode(p2_mode)
);

/* File: bench/phy_mii_control_advert_regs_test.sv */
// self-checking bench for the phy management register bank over axi4-lite
// assumes the checker is bound from its own file
`timescale 1ns/100ps
module phy_mii_control_advert_regs_test;
  import phy_regs_pkg::*;
  typedef struct packed {
    logic [11:0] wa;
    logic [15:0] wd;
    logic [3:0] ws;
    logic [1:0] wr;
    logic [11:0] ra;
    logic [15:0] rd;
    logic [1:0] rr;
  } row_s;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, p1_partner_update;
  logic awready, wready, bvalid, arready, rvalid, p2_restart_pulse;
  logic p2_an_failed, p2_an_speed_100, p2_an_full_duplex;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  ability_s p1_partner_in, port1_adv;
  port2_ctl_s port2_ctl;
  link_mode_s p2_mode;
  int num_errors, comparisons, cycles, pulses;
  row_s rows [10];

  phy_mii_control_advert_regs dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .p1_partner_update(p1_partner_update), .p1_partner_in(p1_partner_in),
    .p2_an_failed(p2_an_failed), .p2_an_speed_100(p2_an_speed_100),
    .p2_an_full_duplex(p2_an_full_duplex), .port2_ctl(port2_ctl), .port1_adv(port1_adv),
    .p2_restart_pulse(p2_restart_pulse), .p2_mode(p2_mode)
  );

  // ----------------------------------------------------------------
  // clock, timeout, report
  // ----------------------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // whole run needs well under a thousand cycles
  always @(posedge aclk)
  begin
    cycles++;
    // pulse stands one cycle, so it is counted here rather than compared later
    if (p2_restart_pulse === 1'b1)
      pulses++;
    if (cycles == 5000)
    begin
      num_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t resp %h exp %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  // stall holds bready low to make the slave keep its response
  task automatic wr(input logic [11:0] a, input logic [15:0] v, input logic [3:0] s,
                    input int stall, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, v};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (stall == 0);
    forever
    begin
      @(posedge aclk);
      if (bvalid === 1'b1 && bready === 1'b1)
        break;
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      // count stall cycles only once the response stands
      if (bvalid === 1'b1)
      begin
        if (n >= stall)
          bready <= 1'b1;
        n++;
      end
    end
    resp = bresp;
    bready <= 1'b0;
  endtask

  // rready rises only after rvalid is seen, so read data must stand a cycle
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (rvalid === 1'b1 && rready === 1'b1)
        break;
      if (arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
        rready <= 1'b1;
    end
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, p1_partner_update} = '0;
    {p2_an_failed, p2_an_speed_100, p2_an_full_duplex} = 3'h1;
    {awaddr, araddr, wdata, wstrb} = '0;
    p1_partner_in = '0;
    rows = '{'{12'h000, 16'hffff, 4'h3, RESP_OKAY, 12'h000, 16'h7b3f, RESP_OKAY},
             '{12'h000, 16'h0000, 4'h3, RESP_OKAY, 12'h000, 16'h0000, RESP_OKAY},
             '{12'h050, 16'hffff, 4'h3, RESP_OKAY, 12'h000, 16'h7b1f, RESP_OKAY},
             '{12'h058, 16'h8000, 4'h3, RESP_OKAY, 12'h000, 16'h7b3f, RESP_OKAY},
             '{12'h000, 16'h0000, 4'h1, RESP_OKAY, 12'h050, 16'h29e0, RESP_OKAY},
             '{12'h020, 16'h0000, 4'h3, RESP_OKAY, 12'h040, 16'h0000, RESP_OKAY},
             '{12'h040, 16'h0015, 4'h3, RESP_OKAY, 12'h020, 16'h04a1, RESP_OKAY},
             '{12'h028, 16'hffff, 4'h3, RESP_OKAY, 12'h028, 16'h0001, RESP_OKAY},
             '{12'h03c, 16'h1234, 4'h3, RESP_SLVERR, 12'h03c, 16'h0000, RESP_SLVERR},
             '{12'h020, 16'h0200, 4'h2, RESP_OKAY, 12'h020, 16'h02a1, RESP_OKAY}};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i].wa, rows[i].wd, rows[i].ws, i % 3, r);
      chk_resp(r, rows[i].wr);
      rd(rows[i].ra, d, r);
      chk_data(d, {16'h0000, rows[i].rd});
      chk_resp(r, rows[i].rr);
    end
    // restart written with the upper lane in both control views, nowhere else
    chk_data(32'(pulses), 32'h0000_0002);
    // field outputs after a loopback-only write
    wr(12'h000, 16'h4000, 4'h3, 0, r);
    chk_data(32'(port2_ctl), 32'h0000_0800);
    chk_data(32'(port1_adv), 32'h0000_0005);
    // forced against negotiated speed; forced and negotiated duplex are both full here
    wr(12'h000, 16'h2100, 4'h3, 0, r);
    repeat (2) @(posedge aclk);
    chk_data(32'(p2_mode), 32'h0000_0003);
    // negotiated duplex high against forced duplex low, so the source shows
    wr(12'h000, 16'h1000, 4'h3, 0, r);
    repeat (2) @(posedge aclk);
    chk_data(32'(p2_mode), 32'h0000_0001);
    p2_an_failed <= 1'b1;
    p2_an_speed_100 <= 1'b1;
    repeat (2) @(posedge aclk);
    chk_data(32'(p2_mode), 32'h0000_0002);
    // partner abilities captured from the phy
    p1_partner_in <= 5'h1b;
    p1_partner_update <= 1'b1;
    @(posedge aclk);
    p1_partner_update <= 1'b0;
    rd(12'h028, d, r);
    chk_data(d, 32'h0000_0561);
    rd(12'h048, d, r);
    chk_data(d, 32'h0000_001b);
    // second reset restores documented defaults
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h000, d, r);
    chk_data(d, 32'h0000_1020);
    rd(12'h020, d, r);
    chk_data(d, 32'h0000_05e1);
    rd(12'h028, d, r);
    chk_data(d, 32'h0000_0001);
    final_report();
  end
endmodule
